// ### hw/aircon_pkg.sv
// Package: timing constants, temperatures, modes and carrier structs for the mode/timer controller
package aircon_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLOCK_HZ              = 10_000_000;
    localparam int unsigned TICK_PERIOD_S         = 1;
    localparam int unsigned TICK_CYCLES           = CLOCK_HZ * TICK_PERIOD_S;
    localparam int unsigned RESTART_WAIT_MIN      = 3;
    localparam int unsigned RESTART_WAIT_S        = RESTART_WAIT_MIN * 60;
    localparam int unsigned FORCED_RUN_S          = 60;
    localparam int unsigned TIME_SAVE_MIN         = 7;
    localparam int unsigned TIME_SAVE_S           = TIME_SAVE_MIN * 60;
    localparam int unsigned DRY_ON_MAX_MIN        = 10;
    localparam int unsigned DRY_ON_MAX_S          = DRY_ON_MAX_MIN * 60;
    localparam int unsigned DRY_OFF_MIN_MIN       = 6;
    localparam int unsigned DRY_OFF_MIN_S         = DRY_OFF_MIN_MIN * 60;
    localparam int unsigned DRY_SWITCH_MIN        = 3;
    localparam int unsigned DRY_SWITCH_S          = DRY_SWITCH_MIN * 60;
    localparam int unsigned AUTO_SAMPLE_S         = 25;
    localparam int unsigned REJUDGE_HOUR          = 1;
    localparam int unsigned REJUDGE_S             = REJUDGE_HOUR * 3600;
    localparam int unsigned REJUDGE_OFF_MIN       = 7;
    localparam int unsigned REJUDGE_OFF_SEC       = 30;
    localparam int unsigned REJUDGE_OFF_S         = REJUDGE_OFF_MIN * 60 + REJUDGE_OFF_SEC;

    localparam int unsigned SEC_W                 = 13;
    localparam logic [SEC_W-1:0] SEC_ZERO         = 13'h0000;
    localparam logic [SEC_W-1:0] SEC_MAX          = 13'h1fff;

    // ************************************************************
    // Temperatures, signed degrees C
    // ************************************************************
    localparam logic signed [7:0] JUDGE_COOL      = 8'sd23;
    localparam logic signed [7:0] JUDGE_DRY       = 8'sd20;
    localparam logic signed [7:0] JUDGE_HEAT_COOL = 8'sd25;
    localparam logic signed [7:0] STD_COOL        = 8'sd25;
    localparam logic signed [7:0] STD_DRY         = 8'sd22;
    localparam logic signed [7:0] STD_HEAT        = 8'sd21;
    localparam logic signed [7:0] OFFSET_STEP     = 8'sd2;
    localparam logic signed [7:0] JUMPER_SHIFT    = 8'sd2;

    // ************************************************************
    // Fan levels and target speeds
    // ************************************************************
    localparam int unsigned FAN_LEVELS            = 8;
    localparam int unsigned RPM_W                 = 11;
    localparam logic [RPM_W-1:0] LOWEST_RPM       = 11'h12c;

    typedef enum logic [2:0] {
        FAN_STOP, lowest_fan_level, super_low_fan_level, FAN_LOW, FAN_MED, FAN_HIGH, FAN_SUPER_HIGH, FAN_QUIET
    } fan_level_t;

    typedef enum logic [1:0] {MODE_OFF, MODE_COOL, MODE_DRY, MODE_HEAT} op_mode_t;
    typedef enum logic [1:0] {SEL_COOL, SEL_DRY, SEL_HEAT, SEL_AUTO} user_mode_t;
    typedef enum logic [1:0] {OFS_STD, OFS_UP, OFS_DOWN} offset_t;

    typedef struct packed {
        logic       power_on;
        user_mode_t mode;
        logic signed [7:0] set_temp;
        offset_t    auto_offset;
        fan_level_t fan_level;
    } user_cmd_t;

    typedef struct packed {
        logic       compressor_on;
        op_mode_t   mode;
        fan_level_t fan_level;
        logic [RPM_W-1:0] fan_rpm;
        logic signed [7:0] target_temp;
    } unit_cmd_t;

endpackage : aircon_pkg

// ### hw/aircon_mode_timer_control.sv
// Compressor interval timing, soft dry sequencing and automatic mode selection
module aircon_mode_timer_control #(
    parameter int unsigned TICK_CYCLES = aircon_pkg::TICK_CYCLES,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_SUPER_HIGH = 11'h438,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_HIGH       = 11'h410,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_MED        = 11'h366,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_LOW        = 11'h2da,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_SUPER_LOW  = 11'h29e,
    parameter logic [aircon_pkg::RPM_W-1:0] RPM_QUIET      = 11'h294
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_reset_n,
    input  wire aircon_pkg::user_cmd_t     i_user,
    input  wire logic signed [7:0]         i_intake_temp,
    input  wire logic                      i_temperature_offset_jumper_open,
    output aircon_pkg::unit_cmd_t          o_unit
);

    typedef enum {
        ST_IDLE, ST_SAMPLE, ST_RUN
    } ctl_state_t;

    typedef enum {
        DRY_WAIT, DRY_FIRST_ON, DRY_FIRST_OFF, DRY_CYCLE
    } dry_state_t;

    localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

    ctl_state_t state_q;
    dry_state_t dry_q;
    aircon_pkg::op_mode_t mode_q;
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick;
    logic comp_q;
    logic comp_d;
    logic [aircon_pkg::SEC_W-1:0] on_secs_q;
    logic [aircon_pkg::SEC_W-1:0] off_secs_q;
    logic [aircon_pkg::SEC_W-1:0] phase_secs_q;
    logic [aircon_pkg::SEC_W-1:0] auto_secs_q;
    logic auto_q;
    logic power_q;
    logic signed [7:0] shift;
    logic signed [7:0] target;
    logic signed [7:0] ofs;
    logic demand;
    logic may_start;
    logic may_stop;
    aircon_pkg::op_mode_t judged;
    aircon_pkg::fan_level_t fan_d;
    logic [aircon_pkg::RPM_W-1:0] rpm_table [aircon_pkg::FAN_LEVELS];

    // ************************************************************
    // One-second tick
    // ************************************************************
    assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge i_clock) begin
        if (!i_reset_n || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
        end
    end

    // ************************************************************
    // Thresholds and targets
    // ************************************************************
    assign shift = i_temperature_offset_jumper_open ? aircon_pkg::JUMPER_SHIFT : 8'sd0;

    always_comb begin
        unique case (i_user.auto_offset)
            aircon_pkg::OFS_UP:   ofs = aircon_pkg::OFFSET_STEP;
            aircon_pkg::OFS_DOWN: ofs = -aircon_pkg::OFFSET_STEP;
            default:              ofs = 8'sd0;
        endcase
    end

    always_comb begin
        if (!auto_q) begin
            target = i_user.set_temp;
        end else begin
            unique case (mode_q)
                aircon_pkg::MODE_COOL: target = aircon_pkg::STD_COOL + shift + ofs;
                aircon_pkg::MODE_DRY:  target = aircon_pkg::STD_DRY + shift + ofs;
                default:               target = aircon_pkg::STD_HEAT + shift + ofs;
            endcase
        end
    end

    // Judgement; ">=" puts the threshold itself in the upper mode
    always_comb begin
        if (state_q == ST_SAMPLE) begin
            if (i_intake_temp >= aircon_pkg::JUDGE_COOL + shift) begin
                judged = aircon_pkg::MODE_COOL;
            end else if (i_intake_temp >= aircon_pkg::JUDGE_DRY + shift) begin
                judged = aircon_pkg::MODE_DRY;
            end else begin
                judged = aircon_pkg::MODE_HEAT;
            end
        end else begin
            unique case (mode_q)
                aircon_pkg::MODE_COOL: judged = (i_intake_temp >= aircon_pkg::JUDGE_COOL + shift)
                                                ? aircon_pkg::MODE_COOL : aircon_pkg::MODE_HEAT;
                aircon_pkg::MODE_DRY:  judged = (i_intake_temp >= aircon_pkg::JUDGE_DRY + shift)
                                                ? aircon_pkg::MODE_DRY : aircon_pkg::MODE_HEAT;
                default:               judged = (i_intake_temp >= aircon_pkg::JUDGE_HEAT_COOL + shift)
                                                ? aircon_pkg::MODE_COOL : aircon_pkg::MODE_HEAT;
            endcase
        end
    end

    // ************************************************************
    // Mode control
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_q     <= ST_IDLE;
            mode_q      <= aircon_pkg::MODE_OFF;
            auto_q      <= 1'b0;
            power_q     <= 1'b0;
            auto_secs_q <= aircon_pkg::SEC_ZERO;
        end else begin
            power_q <= i_user.power_on;
            if (!i_user.power_on) begin
                state_q <= ST_IDLE;
                mode_q  <= aircon_pkg::MODE_OFF;
                auto_q  <= 1'b0;
            end else if (!power_q || state_q == ST_IDLE) begin
                auto_secs_q <= aircon_pkg::SEC_ZERO;
                auto_q      <= (i_user.mode == aircon_pkg::SEL_AUTO);
                if (i_user.mode == aircon_pkg::SEL_AUTO) begin
                    state_q <= ST_SAMPLE;
                    mode_q  <= aircon_pkg::MODE_OFF;
                end else begin
                    state_q <= ST_RUN;
                    unique case (i_user.mode)
                        aircon_pkg::SEL_COOL: mode_q <= aircon_pkg::MODE_COOL;
                        aircon_pkg::SEL_DRY:  mode_q <= aircon_pkg::MODE_DRY;
                        default:              mode_q <= aircon_pkg::MODE_HEAT;
                    endcase
                end
            end else begin
                if (tick && auto_secs_q != aircon_pkg::SEC_MAX) begin
                    auto_secs_q <= auto_secs_q + 13'h0001;
                end
                if (state_q == ST_SAMPLE && tick && auto_secs_q == 13'(aircon_pkg::AUTO_SAMPLE_S - 1)) begin
                    state_q     <= ST_RUN;
                    mode_q      <= judged;
                    auto_secs_q <= aircon_pkg::SEC_ZERO;
                end else if (state_q == ST_RUN && auto_q && tick
                             && auto_secs_q >= 13'(aircon_pkg::REJUDGE_S)
                             && !comp_q && i_intake_temp <= target + 8'sd0
                             && off_secs_q > 13'(aircon_pkg::REJUDGE_OFF_S)) begin
                    // Running compressor blocks this path, so the mode holds
                    mode_q      <= judged;
                    auto_secs_q <= aircon_pkg::SEC_ZERO;
                end else if (state_q == ST_RUN && mode_q == aircon_pkg::MODE_DRY && dry_q == DRY_FIRST_OFF
                             && off_secs_q >= 13'(aircon_pkg::DRY_SWITCH_S)
                             && i_intake_temp > target) begin
                    mode_q <= aircon_pkg::MODE_COOL;
                end
            end
        end
    end

    // ************************************************************
    // Compressor demand and protection timers
    // ************************************************************
    always_comb begin
        unique case (mode_q)
            aircon_pkg::MODE_COOL: demand = (i_intake_temp > target);
            aircon_pkg::MODE_DRY:  demand = (dry_q == DRY_FIRST_ON) ||
                                            (dry_q == DRY_CYCLE && i_intake_temp > target);
            aircon_pkg::MODE_HEAT: demand = (i_intake_temp < target);
            default:               demand = 1'b0;
        endcase
    end

    assign may_start = (off_secs_q >= 13'(aircon_pkg::RESTART_WAIT_S));
    assign may_stop  = (on_secs_q >= 13'(aircon_pkg::FORCED_RUN_S));

    always_comb begin
        comp_d = comp_q;
        if (state_q != ST_RUN) begin
            // Power-off stops immediately; the restart wait still protects the next start
            comp_d = 1'b0;
        end else if (!comp_q && demand && may_start) begin
            comp_d = 1'b1;
        end else if (comp_q && may_stop) begin
            if (!demand) begin
                comp_d = 1'b0;
            end else if (mode_q == aircon_pkg::MODE_COOL && on_secs_q >= 13'(aircon_pkg::TIME_SAVE_S)
                         && i_intake_temp <= target + 8'sd1) begin
                comp_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            comp_q     <= 1'b0;
            on_secs_q  <= aircon_pkg::SEC_ZERO;
            off_secs_q <= aircon_pkg::SEC_ZERO;
        end else begin
            comp_q <= comp_d;
            if (comp_d != comp_q) begin
                on_secs_q  <= aircon_pkg::SEC_ZERO;
                off_secs_q <= aircon_pkg::SEC_ZERO;
            end else if (tick) begin
                if (comp_q && on_secs_q != aircon_pkg::SEC_MAX) begin
                    on_secs_q <= on_secs_q + 13'h0001;
                end
                if (!comp_q && off_secs_q != aircon_pkg::SEC_MAX) begin
                    off_secs_q <= off_secs_q + 13'h0001;
                end
            end
        end
    end

    // ************************************************************
    // Soft dry sequence
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || mode_q != aircon_pkg::MODE_DRY) begin
            dry_q        <= DRY_WAIT;
            phase_secs_q <= aircon_pkg::SEC_ZERO;
        end else begin
            if (tick && phase_secs_q != aircon_pkg::SEC_MAX) begin
                phase_secs_q <= phase_secs_q + 13'h0001;
            end
            unique case (dry_q)
                DRY_WAIT: if (i_intake_temp >= target) begin
                    dry_q        <= DRY_FIRST_ON;
                    phase_secs_q <= aircon_pkg::SEC_ZERO;
                end
                DRY_FIRST_ON: if (phase_secs_q >= 13'(aircon_pkg::DRY_ON_MAX_S)
                                  || (comp_q && comp_d == 1'b0)) begin
                    dry_q        <= DRY_FIRST_OFF;
                    phase_secs_q <= aircon_pkg::SEC_ZERO;
                end
                DRY_FIRST_OFF: if (phase_secs_q >= 13'(aircon_pkg::DRY_OFF_MIN_S)) begin
                    dry_q <= DRY_CYCLE;
                end
                DRY_CYCLE: ;
            endcase
        end
    end

    // ************************************************************
    // Fan level and speed table
    // ************************************************************
    assign rpm_table[aircon_pkg::FAN_STOP]           = '0;
    assign rpm_table[aircon_pkg::lowest_fan_level]   = aircon_pkg::LOWEST_RPM;
    assign rpm_table[aircon_pkg::super_low_fan_level] = RPM_SUPER_LOW;
    assign rpm_table[aircon_pkg::FAN_LOW]            = RPM_LOW;
    assign rpm_table[aircon_pkg::FAN_MED]            = RPM_MED;
    assign rpm_table[aircon_pkg::FAN_HIGH]           = RPM_HIGH;
    assign rpm_table[aircon_pkg::FAN_SUPER_HIGH]     = RPM_SUPER_HIGH;
    assign rpm_table[aircon_pkg::FAN_QUIET]          = RPM_QUIET;

    always_comb begin
        if (state_q == ST_IDLE) begin
            fan_d = aircon_pkg::FAN_STOP;
        end else if (state_q == ST_SAMPLE) begin
            fan_d = aircon_pkg::super_low_fan_level;
        end else begin
            fan_d = i_user.fan_level;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_unit <= '0;
        end else begin
            o_unit.compressor_on <= comp_d;
            o_unit.mode          <= mode_q;
            o_unit.fan_level     <= fan_d;
            o_unit.fan_rpm       <= rpm_table[fan_d];
            o_unit.target_temp   <= target;
        end
    end

endmodule : aircon_mode_timer_control

// ### dv/aircon_env_model.sv
// Far-side model: remote control settings and intake air sensor
module aircon_env_model (
    input  wire aircon_pkg::user_cmd_t i_user_req,
    input  wire logic signed [7:0]     i_temp_req,
    input  wire logic                  i_jumper_req,
    output aircon_pkg::user_cmd_t      o_user,
    output logic signed [7:0]          o_intake_temp,
    output logic                       o_jumper_open
);
    timeunit 1ns;
    timeprecision 1ns;
    // Settings and sensor reading are steady levels; the bench changes them just after an edge
    assign o_user        = i_user_req;
    assign o_intake_temp = i_temp_req;
    assign o_jumper_open = i_jumper_req;
endmodule : aircon_env_model

// ### dv/aircon_mode_timer_control_chk.sv
// Checker: timing and mode relations at the controller ports
module aircon_mode_timer_control_chk #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic                  i_clock,
    input wire logic                  i_reset_n,
    input wire aircon_pkg::user_cmd_t i_user,
    input wire logic signed [7:0]     i_intake_temp,
    input wire aircon_pkg::unit_cmd_t o_unit
);
    timeunit 1ns;
    timeprecision 1ns;
    // One tick of slack: timers count whole ticks of the free-running second
    localparam int unsigned WAIT_MIN = 179 * TICK_CYCLES;
    localparam int unsigned RUN_MIN  = 59 * TICK_CYCLES;
    localparam int unsigned DRY_MAX  = 601 * TICK_CYCLES;
    logic [31:0] off_cnt_q;
    logic [31:0] on_cnt_q;
    logic        dry_first_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    always_ff @(posedge i_clock) begin
        if (!i_reset_n || o_unit.compressor_on) off_cnt_q <= '0;
        else off_cnt_q <= off_cnt_q + 32'h1;
    end
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || !o_unit.compressor_on) on_cnt_q <= '0;
        else on_cnt_q <= on_cnt_q + 32'h1;
    end
    // Only the first soft dry on period is capped; thermostat cycling may run longer
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || o_unit.mode != aircon_pkg::MODE_DRY) dry_first_q <= 1'b1;
        else if ($fell(o_unit.compressor_on)) dry_first_q <= 1'b0;
    end

    sequence s_auto_start;
        $rose(i_user.power_on) && i_user.mode == aircon_pkg::SEL_AUTO && o_unit.mode == aircon_pkg::MODE_OFF;
    endsequence
    sequence s_sampling;
        o_unit.fan_level == aircon_pkg::super_low_fan_level && o_unit.mode == aircon_pkg::MODE_OFF;
    endsequence

    property p_reset_clear;
        @(posedge i_clock) disable iff (1'b0) !i_reset_n |=> o_unit == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
    property p_restart_wait;
        $rose(o_unit.compressor_on) |-> off_cnt_q >= WAIT_MIN;
    endproperty
    a_restart_wait: assert property (p_restart_wait) else $error("compressor restarted too early");
    property p_forced_run;
        $fell(o_unit.compressor_on) && $past(i_user.power_on) && $past(i_user.power_on, 2) |-> $past(on_cnt_q) >= RUN_MIN;
    endproperty
    a_forced_run: assert property (p_forced_run) else $error("compressor run shorter than forced time");
    property p_dry_start;
        $rose(o_unit.compressor_on) && o_unit.mode == aircon_pkg::MODE_DRY |-> $past(i_intake_temp) >= o_unit.target_temp;
    endproperty
    a_dry_start: assert property (p_dry_start) else $error("dry started below setting");
    property p_dry_on_max;
        dry_first_q && o_unit.compressor_on && o_unit.mode == aircon_pkg::MODE_DRY |-> on_cnt_q <= DRY_MAX;
    endproperty
    a_dry_on_max: assert property (p_dry_on_max) else $error("dry on period too long");
    property p_auto_sample;
        s_auto_start |-> ##2 s_sampling;
    endproperty
    a_auto_sample: assert property (p_auto_sample) else $error("auto start without super low fan");
    property p_mode_hold;
        o_unit.compressor_on && $past(o_unit.compressor_on) && i_user.power_on && $past(i_user.power_on)
            |-> $stable(o_unit.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while compressor running");
    property p_power_off;
        $fell(i_user.power_on) |-> ##[1:2] (o_unit.mode == aircon_pkg::MODE_OFF && !o_unit.compressor_on);
    endproperty
    a_power_off: assert property (p_power_off) else $error("unit kept running after switch off");
    property p_lowest_rpm;
        o_unit.fan_level == aircon_pkg::lowest_fan_level |-> o_unit.fan_rpm == aircon_pkg::LOWEST_RPM;
    endproperty
    a_lowest_rpm: assert property (p_lowest_rpm) else $error("lowest fan level speed wrong");
endmodule : aircon_mode_timer_control_chk

bind aircon_mode_timer_control aircon_mode_timer_control_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_user(i_user), .i_intake_temp(i_intake_temp), .o_unit(o_unit));

// ### dv/test_aircon_mode_timer_control.sv
// Testbench: manual cooling, soft dry and automatic mode selection
module test_aircon_mode_timer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  i_clock;
    logic                  i_reset_n;
    aircon_pkg::user_cmd_t user_req;
    logic signed [7:0]     temp_req;
    logic                  jumper_req;
    aircon_pkg::user_cmd_t i_user;
    logic signed [7:0]     i_intake_temp;
    logic                  i_jumper_open;
    aircon_pkg::unit_cmd_t o_unit;
    int                    num_errors;
    int                    compares;

    aircon_env_model u_env (.i_user_req(user_req), .i_temp_req(temp_req), .i_jumper_req(jumper_req),
        .o_user(i_user), .o_intake_temp(i_intake_temp), .o_jumper_open(i_jumper_open));
    // Ten clocks per second keeps hour-scale waits short
    aircon_mode_timer_control #(.TICK_CYCLES(10)) u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_user(i_user), .i_intake_temp(i_intake_temp),
        .i_temperature_offset_jumper_open(i_jumper_open), .o_unit(o_unit));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic drive(input logic on, input aircon_pkg::user_mode_t md, input logic signed [7:0] tmp);
        user_req.power_on = on;
        user_req.mode = md;
        temp_req = tmp;
    endtask : drive
    task automatic wait_comp(input logic lvl, input int lim);
        int n;
        n = 0;
        while (o_unit.compressor_on !== lvl && n < lim) begin
            step(1);
            n++;
        end
        check(o_unit.compressor_on, lvl);
    endtask : wait_comp

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_cool_timing();
        user_req.set_temp = 8'sh14;
        user_req.fan_level = aircon_pkg::lowest_fan_level;
        drive(1'b1, aircon_pkg::SEL_COOL, 8'sh1e);
        step(5);
        check(o_unit.fan_rpm, aircon_pkg::LOWEST_RPM);
        step(1690);
        check(o_unit.compressor_on, 1'b0);
        wait_comp(1'b1, 200);
        temp_req = 8'sh0a;
        step(580);
        check(o_unit.compressor_on, 1'b1);
        drive(1'b0, aircon_pkg::SEL_COOL, 8'sh1e);
        step(3);
        check(o_unit.compressor_on, 1'b0);
        drive(1'b1, aircon_pkg::SEL_COOL, 8'sh1e);
        step(1700);
        check(o_unit.compressor_on, 1'b0);
        wait_comp(1'b1, 200);
        temp_req = 8'sh15;
        step(4100);
        check(o_unit.compressor_on, 1'b1);
        wait_comp(1'b0, 200);
        drive(1'b0, aircon_pkg::SEL_COOL, 8'sh1e);
        step(3);
    endtask : test_cool_timing
    task automatic test_dry_cycle();
        int n;
        user_req.set_temp = 8'sh19;
        drive(1'b1, aircon_pkg::SEL_DRY, 8'sh14);
        step(1900);
        check(o_unit.compressor_on, 1'b0);
        temp_req = 8'sh1a;
        wait_comp(1'b1, 50);
        wait_comp(1'b0, 6100);
        step(1690);
        check(o_unit.mode, aircon_pkg::MODE_DRY);
        n = 0;
        while (o_unit.mode !== aircon_pkg::MODE_COOL && n < 300) begin
            step(1);
            n++;
        end
        check(o_unit.mode, aircon_pkg::MODE_COOL);
    endtask : test_dry_cycle
    task automatic test_auto_case(input logic jmp, input aircon_pkg::offset_t ofs, input logic signed [7:0] tmp);
        logic signed [7:0]    sh;
        logic signed [7:0]    et;
        aircon_pkg::op_mode_t em;
        drive(1'b0, aircon_pkg::SEL_AUTO, tmp);
        jumper_req = jmp;
        user_req.auto_offset = ofs;
        step(3);
        user_req.power_on = 1'b1;
        step(2);
        check(o_unit.fan_level, aircon_pkg::super_low_fan_level);
        step(230);
        check(o_unit.mode, aircon_pkg::MODE_OFF);
        step(40);
        sh = jmp ? aircon_pkg::JUMPER_SHIFT : 8'sh00;
        if (tmp >= aircon_pkg::JUDGE_COOL + sh) begin
            em = aircon_pkg::MODE_COOL;
            et = aircon_pkg::STD_COOL;
        end else if (tmp >= aircon_pkg::JUDGE_DRY + sh) begin
            em = aircon_pkg::MODE_DRY;
            et = aircon_pkg::STD_DRY;
        end else begin
            em = aircon_pkg::MODE_HEAT;
            et = aircon_pkg::STD_HEAT;
        end
        et = et + sh;
        if (ofs == aircon_pkg::OFS_UP) et = et + aircon_pkg::OFFSET_STEP;
        if (ofs == aircon_pkg::OFS_DOWN) et = et - aircon_pkg::OFFSET_STEP;
        check(o_unit.mode, em);
        check(o_unit.target_temp, et);
    endtask : test_auto_case
    task automatic test_rejudge();
        int n;
        test_auto_case(1'b0, aircon_pkg::OFS_STD, 8'sh17);
        temp_req = 8'sh16;
        step(35800);
        check(o_unit.mode, aircon_pkg::MODE_COOL);
        n = 0;
        while (o_unit.mode !== aircon_pkg::MODE_HEAT && n < 400) begin
            step(1);
            n++;
        end
        check(o_unit.mode, aircon_pkg::MODE_HEAT);
        check(o_unit.target_temp, aircon_pkg::STD_HEAT);
    endtask : test_rejudge

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        #8ms;
        num_errors++;
        give_verdict();
    end
    initial begin
        num_errors = 0;
        compares = 0;
        user_req = '0;
        temp_req = 8'sh18;
        jumper_req = 1'b0;
        i_reset_n = 1'b0;
        step(4);
        check(o_unit, '0);
        i_reset_n = 1'b1;
        step(1);
        check(o_unit, '0);
        test_cool_timing();
        test_dry_cycle();
        test_auto_case(1'b0, aircon_pkg::OFS_STD, 8'sh17);
        test_auto_case(1'b0, aircon_pkg::OFS_STD, 8'sh16);
        test_auto_case(1'b0, aircon_pkg::OFS_STD, 8'sh14);
        test_auto_case(1'b0, aircon_pkg::OFS_STD, 8'sh13);
        test_auto_case(1'b1, aircon_pkg::OFS_STD, 8'sh19);
        test_auto_case(1'b1, aircon_pkg::OFS_STD, 8'sh18);
        test_auto_case(1'b1, aircon_pkg::OFS_STD, 8'sh15);
        test_auto_case(1'b0, aircon_pkg::OFS_UP, 8'sh17);
        test_auto_case(1'b0, aircon_pkg::OFS_DOWN, 8'sh13);
        test_rejudge();
        give_verdict();
    end
endmodule : test_aircon_mode_timer_control
